// [verilog/dapwm_top.sv]
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
//
// Operation
// - two 8-bit auxiliary pulse outputs, variable period and on-time
// - mode bit 8 set selects independent, cleared selects offset mode
// - independent mode: separate period and on-time per channel
// - time step two clocks; period is two clocks times value plus one
// - high time is two clocks times the on-time value
// - on-time above period holds output high whole cycle
// - offset mode: both channels use channel 0 period
// - offset mode: output 1 rises offset after output 0
// - writes allowed anytime; new on-time applies next cycle
// - period write resets timers to zero and restarts cycles
// - reset clears mode bit, offset mode default
// - periods reset to 0xFF, on-times reset to 0x00
// - full 8-bit resolution only at period 255
module dapwm_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             aux_out_pin0,
  output logic             aux_out_pin1
);
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        mode_q, mode_d;
  logic [7:0]  per0_q, per0_d;
  logic [7:0]  per1_q, per1_d;
  logic [7:0]  on0_q, on0_d;
  logic [7:0]  on1_q, on1_d;
  logic [31:0] rdata_q, rdata_d;
  logic        restart_q, restart_d;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        in_phase1;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == dapwm_pkg::ADDR_MODE_CTRL)  ||
                  (a == dapwm_pkg::ADDR_PERIOD_CH0) ||
                  (a == dapwm_pkg::ADDR_PERIOD_CH1) ||
                  (a == dapwm_pkg::ADDR_ONTIME_CH0) ||
                  (a == dapwm_pkg::ADDR_ONTIME_CH1) ||
                  (a == dapwm_pkg::ADDR_STATUS);
  endfunction

  // setup cycle: capture read data, then answer in access phase
  assign mapped = addr_mapped(paddr);
  assign wr_en  = psel && penable && pwrite && ce;
  assign rd_en  = psel && !penable && ce;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mode_d    = mode_q;
    per0_d    = per0_q;
    per1_d    = per1_q;
    on0_d     = on0_q;
    on1_d     = on1_q;
    rdata_d   = rdata_q;
    restart_d = 1'b0;
    if (wr_en && mapped) begin
      unique case (paddr)
        dapwm_pkg::ADDR_MODE_CTRL:
          mode_d = pwdata[dapwm_pkg::MODE_SEL_BIT];
        dapwm_pkg::ADDR_PERIOD_CH0: begin
          per0_d    = pwdata[7:0];
          restart_d = 1'b1;
        end
        dapwm_pkg::ADDR_PERIOD_CH1: begin
          per1_d    = pwdata[7:0];
          restart_d = 1'b1;
        end
        dapwm_pkg::ADDR_ONTIME_CH0: on0_d = pwdata[7:0];
        dapwm_pkg::ADDR_ONTIME_CH1: on1_d = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        dapwm_pkg::ADDR_MODE_CTRL:
          rdata_d[dapwm_pkg::MODE_SEL_BIT] = mode_q;
        dapwm_pkg::ADDR_PERIOD_CH0: rdata_d[7:0] = per0_q;
        dapwm_pkg::ADDR_PERIOD_CH1: rdata_d[7:0] = per1_q;
        dapwm_pkg::ADDR_ONTIME_CH0: rdata_d[7:0] = on0_q;
        dapwm_pkg::ADDR_ONTIME_CH1: rdata_d[7:0] = on1_q;
        dapwm_pkg::ADDR_STATUS: begin
          rdata_d[dapwm_pkg::STAT_OUT0_BIT]  = aux_out_pin0;
          rdata_d[dapwm_pkg::STAT_OUT1_BIT]  = aux_out_pin1;
          rdata_d[dapwm_pkg::STAT_PHASE_BIT] = in_phase1;
          rdata_d[dapwm_pkg::STAT_MODE_BIT]  = mode_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q    <= dapwm_pkg::MODE_SEL_RST;
      per0_q    <= dapwm_pkg::PERIOD_RST;
      per1_q    <= dapwm_pkg::PERIOD_RST;
      on0_q     <= dapwm_pkg::ONTIME_RST;
      on1_q     <= dapwm_pkg::ONTIME_RST;
      rdata_q   <= 32'h0000_0000;
      restart_q <= 1'b0;
    end else if (ce) begin
      mode_q    <= mode_d;
      per0_q    <= per0_d;
      per1_q    <= per1_d;
      on0_q     <= on0_d;
      on1_q     <= on1_d;
      rdata_q   <= rdata_d;
      restart_q <= restart_d;
    end
  end

  assign prdata = rdata_q;

  // ----------------------------------------------------------------
  // step prescaler and period timers
  // ----------------------------------------------------------------
  logic       div_q, div_d;
  logic [7:0] tmr0_q, tmr0_d;
  logic [7:0] tmr1_q, tmr1_d;
  logic       ph1_q, ph1_d;
  logic       step;
  logic       wrap0;
  logic       wrap1;
  logic       start0;
  logic       start1;
  logic [7:0] per_ch1;

  assign step = (div_q == 1'b1) && !restart_q;
  // period of value plus one steps
  assign wrap0 = (tmr0_q == per0_q);
  assign wrap1 = (tmr1_q == per1_q);
  assign in_phase1 = ph1_q;
  assign per_ch1 = mode_q ? per1_q : per0_q;

  always_comb begin
    div_d  = div_q;
    tmr0_d = tmr0_q;
    tmr1_d = tmr1_q;
    ph1_d  = ph1_q;
    start0 = 1'b0;
    start1 = 1'b0;
    if (restart_q) begin
      div_d  = 1'b0;
      tmr0_d = 8'h00;
      tmr1_d = 8'h00;
      ph1_d  = 1'b0;
    end else begin
      div_d = ~div_q;
      if (step) begin
        start0 = (tmr0_q == 8'h00);
        tmr0_d = wrap0 ? 8'h00 : tmr0_q + 8'h01;
        if (mode_q) begin
          start1 = (tmr1_q == 8'h00);
          tmr1_d = wrap1 ? 8'h00 : tmr1_q + 8'h01;
        end else begin
          // offset of value plus one steps after output 0
          start1 = ({1'b0, tmr0_q} == {1'b0, per1_q} + 9'h001);
          if (per1_q == per0_q)
            start1 = (tmr0_q == 8'h00);
          ph1_d = ph1_q | start1;
          tmr1_d = tmr0_q;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q  <= 1'b0;
      tmr0_q <= 8'h00;
      tmr1_q <= 8'h00;
      ph1_q  <= 1'b0;
    end else if (ce) begin
      div_q  <= div_d;
      tmr0_q <= tmr0_d;
      tmr1_q <= tmr1_d;
      ph1_q  <= ph1_d;
    end
  end

  // ----------------------------------------------------------------
  // output channels
  // ----------------------------------------------------------------
  dapwm_chan_if c0_if ();
  dapwm_chan_if c1_if ();

  assign c0_if.step      = step;
  assign c0_if.restart   = restart_q;
  assign c0_if.period    = per0_q;
  // on-time taken at cycle start inside channel
  assign c0_if.ontime    = on0_q;
  assign c0_if.start_now = start0;
  assign c1_if.step      = step;
  assign c1_if.restart   = restart_q;
  assign c1_if.period    = per_ch1;
  assign c1_if.ontime    = on1_q;
  assign c1_if.start_now = start1;

  dapwm_chan u_ch0 (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .ch  (c0_if.chan)
  );
  dapwm_chan u_ch1 (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .ch  (c1_if.chan)
  );

  assign aux_out_pin0 = c0_if.out;
  assign aux_out_pin1 = c1_if.out;
endmodule

// [verilog/dapwm_pkg.sv]
package dapwm_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD_CH0  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD_CH1  = 8'h08;
  localparam logic [7:0] ADDR_ONTIME_CH0  = 8'h0C;
  localparam logic [7:0] ADDR_ONTIME_CH1  = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         MODE_SEL_BIT     = 8;
  localparam logic [7:0] PERIOD_RST       = 8'hFF;
  localparam logic [7:0] ONTIME_RST       = 8'h00;
  localparam logic       MODE_SEL_RST     = 1'b0;
  localparam int         STAT_OUT0_BIT    = 0;
  localparam int         STAT_OUT1_BIT    = 1;
  localparam int         STAT_PHASE_BIT   = 2;
  localparam int         STAT_MODE_BIT    = 3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLKS_PER_STEP    = 2;
endpackage

// [verilog/dapwm_chan_if.sv]
`timescale 1ns/100ps
interface dapwm_chan_if;
  logic       step;
  logic       restart;
  logic [7:0] period;
  logic [7:0] ontime;
  logic       start_now;
  logic       out;
  modport ctrl (output step, output restart, output period,
                output ontime, output start_now, input out);
  modport chan (input step, input restart, input period,
                input ontime, input start_now, output out);
endinterface

// [verilog/dapwm_chan.sv]
`timescale 1ns/100ps
module dapwm_chan (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  dapwm_chan_if.chan ch
);
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] on_q, on_d;
  logic       out_q, out_d;
  logic       run_q, run_d;

  // ----------------------------------------------------------------
  // cycle counter and output
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    on_d  = on_q;
    out_d = out_q;
    run_d = run_q;
    if (ch.restart) begin
      cnt_d = 8'h00;
      run_d = 1'b0;
      out_d = 1'b0;
    end else if (ch.step) begin
      if (ch.start_now) begin
        // cycle start: latch on-time, drive high unless on-time is zero
        on_d  = ch.ontime;
        cnt_d = 8'h00;
        run_d = 1'b1;
        out_d = (ch.ontime != 8'h00);
      end else if (run_q) begin
        cnt_d = cnt_q + 8'h01;
        // high for on_q steps; full when on-time beyond period
        out_d = (on_q > ch.period) ||
                ({1'b0, cnt_q} + 9'h001 < {1'b0, on_q});
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      on_q  <= 8'h00;
      out_q <= 1'b0;
      run_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      on_q  <= on_d;
      out_q <= out_d;
      run_q <= run_d;
    end
  end

  assign ch.out = out_q;
endmodule

// [bench/dapwm_assertions.sv]
`timescale 1ns/100ps
module dapwm_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        aux_out_pin0,
  input wire logic        aux_out_pin1
);
  logic       wr;
  logic       per_wr;
  logic [2:0] hist_q;
  logic [9:0] quiet_q;
  logic [7:0] on0_q;
  logic [7:0] per0_q;
  assign wr = psel && penable && pwrite && ce;
  assign per_wr = wr && (paddr == dapwm_pkg::ADDR_PERIOD_CH0
                      || paddr == dapwm_pkg::ADDR_PERIOD_CH1);
  // shadow of channel 0 setup and write history
  always_ff @(posedge clk) begin
    if (rst) begin
      hist_q  <= 3'h0;
      quiet_q <= 10'h000;
      on0_q   <= dapwm_pkg::ONTIME_RST;
      per0_q  <= dapwm_pkg::PERIOD_RST;
    end else begin
      hist_q  <= {hist_q[1:0], wr};
      quiet_q <= wr ? 10'h000 : quiet_q + {9'h000, quiet_q != 10'h3ff};
      if (wr && paddr == dapwm_pkg::ADDR_ONTIME_CH0)
        on0_q <= pwdata[7:0];
      if (wr && paddr == dapwm_pkg::ADDR_PERIOD_CH0)
        per0_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rst_outs_low: assert property (disable iff (1'b0)
    rst |=> !aux_out_pin0 && !aux_out_pin1) else $error("outputs not low");
  a_ready_now: assert property (psel |-> pready)
    else $error("wait state seen");
  a_unmapped_err: assert property (
    psel && penable && paddr > dapwm_pkg::ADDR_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_period_restart: assert property (per_wr |-> ##[1:2]
    (!aux_out_pin0 && !aux_out_pin1)) else $error("no restart");
  a_step_hold0: assert property ($changed(aux_out_pin0)
    && hist_q == 3'h0 && !wr |=> $stable(aux_out_pin0))
    else $error("pin0 edge off step");
  a_step_hold1: assert property ($changed(aux_out_pin1)
    && hist_q == 3'h0 && !wr |=> $stable(aux_out_pin1))
    else $error("pin1 edge off step");
  a_zero_duty: assert property (
    quiet_q > 10'h258 && on0_q == 8'h00 |-> !aux_out_pin0)
    else $error("pin0 high at zero on-time");
  a_full_duty: assert property (
    quiet_q > 10'h258 && on0_q > per0_q |-> aux_out_pin0)
    else $error("pin0 low at full duty");
endmodule

// [bench/dapwm_load.sv]
`timescale 1ns/100ps
module dapwm_load (
  input  wire logic        clk,
  input  wire logic [1:0]  pin,
  output logic [1:0][15:0] hi_len,
  output logic [1:0][15:0] per_len,
  output logic [15:0]      lag
);
  logic [1:0]       prev_q = 2'b00;
  logic [1:0][15:0] since_q;
  logic [1:0][15:0] hcnt_q;
  // pulse width, period and phase lag of both switches
  always @(posedge clk) begin
    prev_q <= pin;
    for (int c = 0; c < 2; c++) begin
      since_q[c] <= since_q[c] + 16'h0001;
      hcnt_q[c]  <= hcnt_q[c] + 16'h0001;
      if (pin[c] && !prev_q[c]) begin
        per_len[c] <= since_q[c];
        since_q[c] <= 16'h0001;
        hcnt_q[c]  <= 16'h0001;
      end
      if (!pin[c] && prev_q[c])
        hi_len[c] <= hcnt_q[c];
    end
    if (pin[1] && !prev_q[1])
      lag <= since_q[0];
  end
endmodule

// [bench/dual_aux_pwm_timers_test.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  fail_count++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module dual_aux_pwm_timers_test;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  logic [31:0]      stat_exp;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0000_0000;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [1:0]       pin;
  logic [1:0][15:0] hi_len;
  logic [1:0][15:0] per_len;
  logic [15:0]      lag;
  logic [31:0]      rd_q;
  logic             err_q;
  logic             md;
  logic [7:0]       p0;
  int               fail_count = 0;
  int               n_checks = 0;
  always #25 clk = ~clk;
  dapwm_top u_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_out_pin0(pin[0]), .aux_out_pin1(pin[1]));
  dapwm_load u_load (.clk(clk), .pin(pin), .hi_len(hi_len),
    .per_len(per_len), .lag(lag));
  function automatic logic [15:0] steps(input logic [8:0] n);
    return {6'h00, n, 1'b0};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {23'h00_0000, w && a == 8'h00 && md, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_pin(input logic lvl);
    while (pin[0] !== lvl) @(posedge clk);
  endtask
  task automatic run_cfg(input logic [7:0] p1, o0, o1);
    logic [7:0] pe [2];
    logic [7:0] on [2];
    logic [1:0] any_hi;
    logic [1:0] all_hi;
    int         mx;
    pe = '{p0, md ? p1 : p0};
    on = '{o0, o1};
    any_hi = 2'b00;
    all_hi = 2'b11;
    apb(1'b1, dapwm_pkg::ADDR_MODE_CTRL, 8'h00);
    apb(1'b1, dapwm_pkg::ADDR_ONTIME_CH0, o0);
    apb(1'b1, dapwm_pkg::ADDR_ONTIME_CH1, o1);
    apb(1'b1, dapwm_pkg::ADDR_PERIOD_CH0, p0);
    apb(1'b1, dapwm_pkg::ADDR_PERIOD_CH1, p1);
    mx = (p0 > p1) ? p0 : p1;
    // window opens once both channels have run a full cycle
    for (int k = 0; k < 6 * mx + 730; k++) begin
      @(posedge clk);
      if (k == 4 * mx + 12) begin
        any_hi = pin;
        all_hi = pin;
      end else begin
        any_hi = any_hi | pin;
        all_hi = all_hi & pin;
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (on[c] == 8'h00)
        `CHK("idle pin", 1'b0, any_hi[c])
      else if (on[c] > pe[c])
        `CHK("full pin", 1'b1, all_hi[c])
      else begin
        `CHK("high time", steps(on[c]), hi_len[c])
        `CHK("period", steps(pe[c] + 9'h001), per_len[c])
      end
    end
    if (!md && o0 != 0 && o0 <= p0 && o1 != 0 && o1 <= p0)
      `CHK("offset", steps(p1 + 9'h001), lag)
    apb(1'b0, dapwm_pkg::ADDR_MODE_CTRL, 8'h00);
    `CHK("mode reg", {23'h0, md, 8'h00}, rd_q)
    $display("test config mode %0d done", md);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h9e3e_a3b3));
    md = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i + (i / 5) * 4), 8'h00);
      `CHK("reset value", 32'((i == 1 || i == 2) ? 8'hff : 8'h00), rd_q)
    end
    `CHK("unmapped", 1'b1, err_q)
    $display("test reset values done");
    md = 1'b1;
    p0 = 8'h03;
    run_cfg(8'h09, 8'h07, 8'h00);
    md = 1'b0;
    p0 = 8'hff;
    run_cfg(8'hfe, 8'hff, 8'h01);
    md = 1'b1;
    p0 = 8'h05;
    run_cfg(8'h05, 8'h00, 8'h06);
    repeat (6) begin
      md = 1'($urandom);
      p0 = 8'($urandom_range(40, 1));
      run_cfg(8'($urandom_range(md ? 40 : p0 - 1, 0)),
              8'($urandom_range(p0 + 2, 0)), 8'($urandom_range(41, 0)));
    end
    md = 1'b1;
    p0 = 8'hff;
    run_cfg(8'hff, 8'h64, 8'h00);
    wait_pin(1'b0);
    wait_pin(1'b1);
    repeat (20) @(posedge clk);
    apb(1'b1, dapwm_pkg::ADDR_ONTIME_CH0, 8'h14);
    wait_pin(1'b0);
    repeat (2) @(posedge clk);
    `CHK("old on-time", steps(9'h064), hi_len[0])
    wait_pin(1'b1);
    wait_pin(1'b0);
    repeat (2) @(posedge clk);
    `CHK("new on-time", steps(9'h014), hi_len[0])
    $display("test on-time update done");
    stat_exp = 32'((1 << dapwm_pkg::STAT_OUT0_BIT)
                   | (1 << dapwm_pkg::STAT_MODE_BIT));
    wait_pin(1'b0);
    wait_pin(1'b1);
    apb(1'b0, dapwm_pkg::ADDR_STATUS, 8'h00);
    `CHK("status", stat_exp, rd_q)
    // enable low must hold the pulse past its on-time
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    `CHK("frozen pin", 1'b1, pin[0])
    ce <= 1'b1;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, dapwm_pkg::ADDR_MODE_CTRL, 8'h00);
    `CHK("mode after reset", 32'h0000_0000, rd_q)
    apb(1'b0, dapwm_pkg::ADDR_PERIOD_CH1, 8'h00);
    `CHK("period after reset", 32'h0000_00ff, rd_q)
    $display("test freeze and reset done");
    summarize();
  end
endmodule
bind dapwm_top dapwm_assertions u_chk (.clk(clk), .rst(rst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .aux_out_pin0(aux_out_pin0), .aux_out_pin1(aux_out_pin1));
